// >>> rtl/cfes_pkg.sv
// Shared constants and types for the fetch/execute sequencer.
// Assumes a single 10 MHz clock; no other package is needed.
package cfes_pkg;

  // ---------------------------------------------------------------
  // Clock and widths
  // ---------------------------------------------------------------
  localparam int          CFES_CLK_MHZ     = 10;        // Oscillator rate in MHz
  localparam int          CFES_PHASES      = 4;         // Oscillator periods per cycle
  localparam int          CFES_PC_W        = 13;        // Instruction pointer width
  localparam int          CFES_OP_W        = 14;        // Program word width
  localparam int          CFES_OFS_W       = 7;         // Bank offset width
  localparam int          CFES_DADR_W      = 8;         // Bank bit plus offset
  localparam int          CFES_PB_HI_W     = 4;         // Upper port-B pins

  // ---------------------------------------------------------------
  // Program space
  // ---------------------------------------------------------------
  localparam logic [12:0] CFES_TOP_FULL    = 13'h1FFF;  // 8K words
  localparam logic [12:0] CFES_TOP_512     = 13'h01FF;  // Small variant top
  localparam logic [12:0] CFES_TOP_1K      = 13'h03FF;  // Mid variant top
  localparam logic [12:0] CFES_TOP_2K      = 13'h07FF;  // Large variant top
  localparam logic [12:0] CFES_RESET_VEC   = 13'h0000;  // Fetch start after reset
  localparam logic [12:0] CFES_IRQ_VEC     = 13'h0004;  // Interrupt entry
  localparam logic [12:0] CFES_PC_STEP     = 13'h0001;  // Increment per cycle

  // ---------------------------------------------------------------
  // Data memory
  // ---------------------------------------------------------------
  localparam int          CFES_STATUS_BANK_POS = 5;      // Bank bit in status
  localparam logic [6:0]  CFES_BANK_TOP    = 7'h7F;      // Last offset of a bank
  localparam logic [6:0]  CFES_MIR_INDIR   = 7'h00;      // Mirrored offsets
  localparam logic [6:0]  CFES_MIR_PCLO    = 7'h02;
  localparam logic [6:0]  CFES_MIR_STATUS  = 7'h03;
  localparam logic [6:0]  CFES_MIR_FSEL    = 7'h04;
  localparam logic [6:0]  CFES_MIR_PCHI    = 7'h0A;
  localparam logic [6:0]  CFES_MIR_INTCTL  = 7'h0B;

  // ---------------------------------------------------------------
  // Phase encoding, one-hot
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    CFES_PH_ONE   = 4'h1,
    CFES_PH_TWO   = 4'h2,
    CFES_PH_THREE = 4'h4,
    CFES_PH_FOUR  = 4'h8
  } cfes_phase_t;

  // Redirect request from the execute unit
  typedef struct packed {
    logic                 take;     // Instruction alters the pointer
    logic [CFES_PC_W-1:0] target;   // New fetch address
  } cfes_redirect_t;

  // Data access request decoded from the latched opcode
  typedef struct packed {
    logic                  rd;      // Operand read needed
    logic                  wr;      // Destination write needed
    logic [CFES_OFS_W-1:0] offset;  // Offset inside the bank
  } cfes_dreq_t;

endpackage : cfes_pkg

// >>> rtl/cfes_phase_gen.sv
// Four-phase generator: divides the oscillator by four.
// Assumes clk is the oscillator and rst_b a synchronous active-low reset.
`timescale 1ns/1ps
module cfes_phase_gen
  import cfes_pkg::*;
(
  input  wire logic        clk,      // Oscillator input
  input  wire logic        rst_b,    // Synchronous reset, active low
  output cfes_phase_t      phase_q   // Current phase, one-hot
);

  // ---------------------------------------------------------------
  // Phase rotation
  // ---------------------------------------------------------------
  cfes_phase_t phase_d;              // Next phase

  // Step through the four phases in order
  always_comb
  begin
    unique case (phase_q)
      CFES_PH_ONE:   phase_d = CFES_PH_TWO;
      CFES_PH_TWO:   phase_d = CFES_PH_THREE;
      CFES_PH_THREE: phase_d = CFES_PH_FOUR;
      CFES_PH_FOUR:  phase_d = CFES_PH_ONE;
      default:       phase_d = CFES_PH_ONE;
    endcase
  end

  // Reset parks in phase one so the first cycle starts at once
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      phase_q <= CFES_PH_ONE;
    else
      phase_q <= phase_d;
  end

endmodule // cfes_phase_gen

// >>> rtl/cfes_core_seq.sv
// Fetch/execute sequencer of an 8-bit controller core.
// Assumes a program memory with combinational read, an external decoder
// driving dreq from the latched opcode, and inputs synchronous to clk.
//
// Functional notes
// - Oscillator divided by four into phases
// - Pointer advances once per cycle, phase one
// - Opcode captured from program memory, phase four
// - Latch loads phase one, executes after
// - Operand read phase two, write phase four
// - Fetch overlaps execute, one per cycle
// - Pointer change costs two cycles, flushes fetch
// - Pointer is 13 bits, 8K words
// - Addresses above implemented top wrap around
// - Reset starts at zero, interrupt at four
// - Status bit five selects data bank
// - Each bank spans offsets to 7Fh
// - Frequent bank-zero registers mirrored in bank one
// - Upper port-B pins flag input changes
// - Programming clock bit six, data bit seven
// - RC mode outputs quarter-rate cycle clock
`timescale 1ns/1ps
module cfes_core_seq
  import cfes_pkg::*;
#(
  parameter logic [CFES_PC_W-1:0] PROG_TOP = CFES_TOP_2K  // Implemented top
)
(
  input  wire logic                    clk,                // Oscillator input
  input  wire logic                    rst_b,              // Sync reset, low
  input  wire logic [CFES_OP_W-1:0]    pmem_rdata,         // Program word
  input  wire cfes_redirect_t          redirect,           // Branch from execute
  input  wire logic                    irq_req,            // Interrupt pending
  input  wire cfes_dreq_t              dreq,               // Data access request
  input  wire logic [7:0]              status_in,          // Status register
  input  wire logic [CFES_PB_HI_W-1:0] port_b_hi,          // Pins four to seven
  input  wire logic                    prog_mode,          // Serial programming
  input  wire logic                    rc_mode,            // RC oscillator mode
  output cfes_phase_t                  phase_q,            // Current phase
  output logic [CFES_PC_W-1:0]         pmem_addr_q,        // Fetch address
  output logic [CFES_OP_W-1:0]         fetched_opcode_latch, // Executing opcode
  output logic                         exec_valid_q,       // Opcode is real
  output logic                         irq_ack_q,          // Vector taken
  output logic [CFES_DADR_W-1:0]       dmem_addr_q,        // Bank and offset
  output logic                         dmem_rd_q,          // Operand read
  output logic                         dmem_wr_q,          // Destination write
  output logic [CFES_PB_HI_W-1:0]      pb_change_q,        // Change events
  output logic                         prog_clk_q,         // Programming clock
  output logic                         prog_data_q,        // Programming data
  output logic                         osc_output_pin      // Cycle clock out
);

  // ---------------------------------------------------------------
  // Phase generator
  // ---------------------------------------------------------------
  // four phases per cycle
  cfes_phase_gen u_phase (
    .clk     (clk),
    .rst_b   (rst_b),
    .phase_q (phase_q)
  );

  // ---------------------------------------------------------------
  // Decoding
  // ---------------------------------------------------------------
  // Offsets visible in both banks
  function automatic logic is_mirrored(input logic [CFES_OFS_W-1:0] ofs);
    is_mirrored = (ofs == CFES_MIR_INDIR)  || (ofs == CFES_MIR_PCLO)  ||
                  (ofs == CFES_MIR_STATUS) || (ofs == CFES_MIR_FSEL)  ||
                  (ofs == CFES_MIR_PCHI)   || (ofs == CFES_MIR_INTCTL);
  endfunction

  logic [CFES_PC_W-1:0] pc_q;            // Instruction pointer
  logic [CFES_PC_W-1:0] pc_d;            // Next pointer
  logic [CFES_OP_W-1:0] fetch_buf_q;     // Word captured by fetch
  logic                 buf_valid_q;     // Captured word will execute
  logic                 fetching_q;      // A fetch is under way
  logic [CFES_PB_HI_W-1:0] pb_last_q;    // Previous pin levels

  wire run        = !prog_mode;                               // Core active
  wire ph1        = run && (phase_q == CFES_PH_ONE);
  wire ph2        = run && (phase_q == CFES_PH_TWO);
  wire ph4        = run && (phase_q == CFES_PH_FOUR);
  wire take_br    = exec_valid_q && redirect.take;            // Branch ends
  wire take_irq   = exec_valid_q && !redirect.take && irq_req;
  wire flush      = take_br || take_irq;                      // Discard fetch
  wire bank_sel   = status_in[CFES_STATUS_BANK_POS];
  wire eff_bank   = bank_sel && !is_mirrored(dreq.offset);
  wire [CFES_OFS_W-1:0] eff_ofs = dreq.offset & CFES_BANK_TOP;
  wire [CFES_PC_W-1:0]  wrap_pc = pc_q & PROG_TOP;
  wire [CFES_PB_HI_W-1:0] pb_mask = prog_mode ? 4'h3 : 4'hF;  // Pins six, seven busy

  // Next pointer: redirect at phase four, step at phase one
  always_comb
  begin
    pc_d = pc_q;
    if (ph4 && take_br)
      pc_d = redirect.target;
    else if (ph4 && take_irq)
      pc_d = CFES_IRQ_VEC;
    else if (ph1)
      pc_d = wrap_pc + CFES_PC_STEP;
  end

  // ---------------------------------------------------------------
  // Fetch stage
  // ---------------------------------------------------------------
  // pointer register
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      pc_q <= CFES_RESET_VEC;
    else
      pc_q <= pc_d;
  end

  // Fetch address presented for the whole cycle
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      pmem_addr_q <= CFES_RESET_VEC;
    else if (ph1)
      pmem_addr_q <= wrap_pc;
  end

  // capture word, drop it on a redirect
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      fetching_q  <= 1'b0;
      fetch_buf_q <= '0;
      buf_valid_q <= 1'b0;
    end
    else
    begin
      if (ph1)
        fetching_q <= 1'b1;
      if (ph4)
      begin
        fetch_buf_q <= pmem_rdata;
        buf_valid_q <= fetching_q && !flush;
      end
    end
  end

  // ---------------------------------------------------------------
  // Execute stage
  // ---------------------------------------------------------------
  // latch opcode, flushed one is invalid
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      fetched_opcode_latch <= '0;
      exec_valid_q         <= 1'b0;
    end
    else if (ph1)
    begin
      fetched_opcode_latch <= fetch_buf_q;
      exec_valid_q         <= buf_valid_q;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
      irq_ack_q <= 1'b0;
    else
      irq_ack_q <= ph4 && take_irq;
  end

  // data strobes on phases two and four
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      dmem_addr_q <= '0;
      dmem_rd_q   <= 1'b0;
      dmem_wr_q   <= 1'b0;
    end
    else
    begin
      dmem_addr_q <= {eff_bank, eff_ofs};
      dmem_rd_q   <= ph2 && exec_valid_q && dreq.rd;
      dmem_wr_q   <= ph4 && exec_valid_q && dreq.wr;
    end
  end

  // ---------------------------------------------------------------
  // Pins
  // ---------------------------------------------------------------
  // change detect on the upper port-B pins
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      // Track the pins in reset too, so no false change follows release
      pb_last_q   <= port_b_hi;
      pb_change_q <= '0;
    end
    else
    begin
      pb_last_q   <= port_b_hi;
      pb_change_q <= (port_b_hi ^ pb_last_q) & pb_mask;
    end
  end

  // programming clock and data from bits six and seven
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      prog_clk_q  <= 1'b0;
      prog_data_q <= 1'b0;
    end
    else
    begin
      prog_clk_q  <= prog_mode && port_b_hi[2];
      prog_data_q <= prog_mode && port_b_hi[3];
    end
  end

  // quarter-rate clock, high for phases one and two
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      osc_output_pin <= 1'b0;
    else
      osc_output_pin <= rc_mode &&
                        ((phase_q == CFES_PH_FOUR) || (phase_q == CFES_PH_ONE));
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_four_phases;
    (phase_q == CFES_PH_ONE) ##1 (phase_q == CFES_PH_TWO) ##1
    (phase_q == CFES_PH_THREE) ##1 (phase_q == CFES_PH_FOUR);
  endsequence

  a_phase_rotate: assert property (
    (phase_q == CFES_PH_ONE) |-> s_four_phases ##1 (phase_q == CFES_PH_ONE))
    else $error("phase order broken");

  a_pc_step: assert property (
    ph1 |=> (pc_q == (($past(pc_q) & PROG_TOP) + CFES_PC_STEP)))
    else $error("pointer did not step on phase one");

  a_pc_hold: assert property (
    (run && (phase_q == CFES_PH_TWO)) |=> (pc_q == $past(pc_q)) [*2])
    else $error("pointer moved outside phases one and four");

  a_opcode_capture: assert property (
    ph4 |=> (fetch_buf_q == $past(pmem_rdata)))
    else $error("fetched word not captured on phase four");

  a_latch_load: assert property (
    ph1 |=> (fetched_opcode_latch == $past(fetch_buf_q)) &&
            (exec_valid_q == $past(buf_valid_q)))
    else $error("opcode latch not loaded on phase one");

  a_read_phase: assert property (
    dmem_rd_q |-> ($past(phase_q) == CFES_PH_TWO) && $past(exec_valid_q))
    else $error("operand read outside phase two");

  a_write_phase: assert property (
    dmem_wr_q |-> ($past(phase_q) == CFES_PH_FOUR) && $past(exec_valid_q))
    else $error("destination write outside phase four");

  a_branch_flush: assert property (
    (ph4 && take_br) |=> (pc_q == $past(redirect.target)) && !buf_valid_q
      ##1 (!exec_valid_q) [*4])
    else $error("branch did not flush the fetched word");

  a_flush_nop: assert property (
    !exec_valid_q |=> !dmem_wr_q && !dmem_rd_q && !irq_ack_q)
    else $error("flushed cycle had side effects");

  a_addr_wrap: assert property (
    (pmem_addr_q & ~PROG_TOP) == '0)
    else $error("fetch address above implemented top");

  a_irq_vector: assert property (
    (ph4 && take_irq) |=> (pc_q == CFES_IRQ_VEC) && irq_ack_q)
    else $error("interrupt did not vector to four");

  a_reset_state: assert property (
    $rose(rst_b) |-> (pc_q == CFES_RESET_VEC) && !exec_valid_q && !buf_valid_q)
    else $error("reset left pipeline state");

  a_bank_map: assert property (
    1'b1 |=> dmem_addr_q[CFES_DADR_W-1] ==
             ($past(bank_sel) && !is_mirrored($past(dreq.offset))))
    else $error("bank bit not applied");

  a_cycle_clock: assert property (
    (rc_mode && $past(rc_mode) && $past(rst_b)) |->
      (osc_output_pin == ((phase_q == CFES_PH_ONE) || (phase_q == CFES_PH_TWO))))
    else $error("cycle clock out of step");

endmodule // cfes_core_seq

// >>> verif/cfes_pmem_model.sv
// Program memory model for the sequencer bench.
// Assumes the core hands over an address already wrapped to its top.
`timescale 1ns/1ps
module cfes_pmem_model
  import cfes_pkg::*;
(
  input  wire logic [CFES_PC_W-1:0] addr,   // Fetch address
  output logic      [CFES_OP_W-1:0] rdata   // Program word
);
  // Each word carries its own address so fetches can be told apart
  assign rdata = {1'b1, addr};
endmodule // cfes_pmem_model

// >>> verif/tb_cfes_core_seq.sv
// Self-checking bench for the fetch/execute sequencer.
// Assumes the patterned program memory model and a 10 MHz clock.
`timescale 1ns/1ps
module tb_cfes_core_seq import cfes_pkg::*;;
  localparam logic [12:0] TOP = CFES_TOP_512;  // Small variant, short wrap
  // ---------------------------------------------------------------
  // Stimulus and observed signals
  // ---------------------------------------------------------------
  logic           clk       = 1'b0;   // Oscillator
  logic           rst_b     = 1'b0;   // Reset, active low
  logic           irq_req   = 1'b0;   // Interrupt pending
  logic           prog_mode = 1'b0;   // Serial programming
  logic           rc_mode   = 1'b0;   // RC oscillator mode
  logic [7:0]     status_in = 8'h00;  // Status, bank bit five
  logic [3:0]     port_b_hi = 4'h0;   // Pins four to seven
  cfes_redirect_t redirect  = '0;     // Branch request
  cfes_dreq_t     dreq      = '0;     // Data access request
  logic [12:0]    pmem_addr;          // Fetch address
  logic [13:0]    pmem_rdata;         // Program word
  logic [13:0]    latch;              // Executing opcode
  cfes_phase_t    phase;              // Current phase
  logic           valid, ack, rd, wr; // Pipeline and strobes
  logic           pclk, pdata, osc;   // Pin copies
  logic [7:0]     daddr;              // Data address
  logic [3:0]     pbc;                // Change events
  int             fail_count  = 0;    // Mismatches
  int             check_count = 0;    // Comparisons

  cfes_core_seq #(.PROG_TOP(TOP)) i_cfes_core_seq (
    .clk(clk), .rst_b(rst_b), .pmem_rdata(pmem_rdata), .redirect(redirect),
    .irq_req(irq_req), .dreq(dreq), .status_in(status_in), .port_b_hi(port_b_hi),
    .prog_mode(prog_mode), .rc_mode(rc_mode), .phase_q(phase), .pmem_addr_q(pmem_addr),
    .fetched_opcode_latch(latch), .exec_valid_q(valid), .irq_ack_q(ack),
    .dmem_addr_q(daddr), .dmem_rd_q(rd), .dmem_wr_q(wr), .pb_change_q(pbc),
    .prog_clk_q(pclk), .prog_data_q(pdata), .osc_output_pin(osc));

  cfes_pmem_model i_cfes_pmem_model (.addr(pmem_addr), .rdata(pmem_rdata));

  // Clock, inverted each half period
  always #50 clk = ~clk;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d errors %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Pass n edges, then step clear of them
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Wait, bounded, until the next edge is the edge of phase p
  task automatic to_phase(input cfes_phase_t p);
    int n;
    n = 0;
    while (phase !== p && n < 8)
    begin
      tick(1);
      n++;
    end
    if (phase !== p)
    begin
      fail_count++;
      wrap_up();
    end
  endtask

  function automatic logic [13:0] word(input logic [12:0] a);
    return {1'b1, a};
  endfunction

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  // reset and start
  task automatic t_reset();
    rst_b = 1'b0;
    tick(8);
    chk("rst phase", phase, CFES_PH_ONE);
    chk("rst addr", pmem_addr, 13'h0000);
    chk("rst valid", valid, 1'b0);
    rst_b = 1'b1;
    tick(1);
    chk("first addr", pmem_addr, 13'h0000);
    chk("first phase", phase, CFES_PH_TWO);
    tick(3);
    chk("early valid", valid, 1'b0);
    tick(1);
    chk("first op", latch, word(13'h0000));
    chk("first valid", valid, 1'b1);
  endtask

  task automatic t_phase(input logic rcm);
    rc_mode = rcm;
    tick(4);
    to_phase(CFES_PH_ONE);
    for (int k = 0; k < 8; k++)
    begin
      chk("phase", phase, 4'h1 << (k % 4));
      chk("cycle clock", osc, rcm && (k % 4) < 2);
      tick(1);
    end
  endtask

  task automatic t_fetch();
    logic [12:0] a;
    to_phase(CFES_PH_ONE);
    a = pmem_addr;
    repeat (3)
    begin
      tick(1);
      chk("fetch addr", pmem_addr, (a + 13'h0001) & TOP);
      chk("latched op", latch, word(a));
      chk("run valid", valid, 1'b1);
      a = pmem_addr;
      tick(3);
    end
  endtask

  task automatic t_data();
    logic [6:0] ofs [4] = '{7'h20, 7'h20, 7'h03, 7'h7F};
    logic       bnk [4] = '{1'b1, 1'b0, 1'b1, 1'b1};
    logic       exb [4] = '{1'b1, 1'b0, 1'b0, 1'b1};
    for (int i = 0; i < 4; i++)
    begin
      to_phase(CFES_PH_TWO);
      status_in = {2'b00, bnk[i], 5'h00};
      dreq = '{rd: 1'b1, wr: 1'b1, offset: ofs[i]};
      tick(1);
      chk("read strobe", rd, 1'b1);
      chk("data addr", daddr, {exb[i], ofs[i]});
      tick(2);
      chk("write strobe", wr, 1'b1);
      chk("write addr", daddr, {exb[i], ofs[i]});
      dreq = '0;
    end
    status_in = 8'h00;
  endtask

  task automatic t_branch(input logic [12:0] target, input logic with_irq);
    logic [3:0]  n;
    logic [12:0] w;
    n = 4'h0;
    w = target & TOP;
    to_phase(CFES_PH_FOUR);
    redirect = '{take: 1'b1, target: target};
    irq_req = with_irq;
    tick(1);
    redirect = '0;
    irq_req = 1'b0;
    dreq = '{rd: 1'b1, wr: 1'b1, offset: 7'h30};
    chk("branch over irq", ack, 1'b0);
    tick(1);
    chk("branch addr", pmem_addr, w);
    chk("flush valid", valid, 1'b0);
    repeat (3)
    begin
      tick(1);
      n += rd | wr;
    end
    dreq = '0;
    chk("flush strobes", n, 0);
    tick(1);
    chk("target op", latch, word(w));
    chk("target valid", valid, 1'b1);
    chk("wrap addr", pmem_addr, (w + 13'h0001) & TOP);
  endtask

  task automatic t_irq();
    to_phase(CFES_PH_FOUR);
    irq_req = 1'b1;
    tick(1);
    irq_req = 1'b0;
    chk("irq ack", ack, 1'b1);
    tick(1);
    chk("ack pulse", ack, 1'b0);
    chk("vector addr", pmem_addr, CFES_IRQ_VEC);
    chk("irq flush", valid, 1'b0);
    tick(4);
    chk("vector op", latch, word(13'h0004));
  endtask

  task automatic t_pins();
    logic [3:0] acc;
    logic [3:0] v;
    logic [12:0] a;
    for (int i = 0; i < 4; i++)
    begin
      port_b_hi[i] = 1'b1;
      acc = 4'h0;
      repeat (3)
      begin
        tick(1);
        acc |= pbc;
      end
      chk("pin change", acc, 4'h1 << i);
    end
    prog_mode = 1'b1;
    tick(2);
    a = pmem_addr;
    for (int j = 0; j < 2; j++)
    begin
      v = j ? 4'hB : 4'h7;
      port_b_hi = v;
      acc = 4'h0;
      repeat (3)
      begin
        tick(1);
        acc |= pbc;
      end
      chk("prog mask", acc, 4'h0);
      chk("prog clock", pclk, v[2]);
      chk("prog data", pdata, v[3]);
    end
    chk("prog freeze", pmem_addr, a);
    prog_mode = 1'b0;
    tick(2);
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial
  begin
    t_reset();
    t_phase(1'b0);
    t_phase(1'b1);
    t_fetch();
    t_data();
    t_branch(13'h1205, 1'b0);
    t_branch(13'h01FF, 1'b1);
    t_irq();
    t_pins();
    t_reset();
    t_fetch();
    wrap_up();
  end
endmodule // tb_cfes_core_seq
